// ===== src/lasc_map.svh
// timing constants and pattern figures of the leak alarm status controller
// Notes on behaviour
// - While a leak is being sensed the controller sits in alarm mode and flashes the lamp fast.
// - Once an alarm or fault clears the controller holds a mitigation delay of five minutes.
// - Throughout the delay the lamp stays lit without flashing.
// - Two button presses inside five seconds start the verification test.
// - The verification test acts as a simulated alarm for five minutes, then returns to normal.
// - One button press during the test ends it at once and returns to normal.
// - An internal board fault shows two flashes followed by five seconds dark, repeating.
// - A sensor link fault shows three flashes followed by five seconds dark, repeating.
// - A fault reported by the sensor shows four flashes followed by five seconds dark.
// - Loss of message exchange with the sensor, unplugged included, is a link fault.
// - A sensor fault is reported only while the link works and the sensor flags a failure.
// - In normal operation the lamp is lit two seconds and dark two seconds, repeating.
// - The verification test shows the same fast flashing as a real alarm.
`ifndef LASC_MAP_SVH
`define LASC_MAP_SVH

// ****************************************
// clock and base tick
// ****************************************
`define LASC_CLK_HZ 250000000
`define LASC_FAST_MS 100
`define LASC_FAST_CYCLES ((`LASC_CLK_HZ / 1000) * `LASC_FAST_MS)
`define LASC_TICK_PER_S (1000 / `LASC_FAST_MS)

// ****************************************
// mode durations
// ****************************************
`define LASC_DELAY_MIN 5
`define LASC_TEST_MIN 5
`define LASC_DELAY_TICKS (`LASC_DELAY_MIN * 60 * `LASC_TICK_PER_S)
`define LASC_TEST_TICKS (`LASC_TEST_MIN * 60 * `LASC_TICK_PER_S)
`define LASC_PRESS_WIN_S 5
`define LASC_PRESS_WIN_TICKS (`LASC_PRESS_WIN_S * `LASC_TICK_PER_S)
`define LASC_SETTLE_S 1
`define LASC_SETTLE_TICKS (`LASC_SETTLE_S * `LASC_TICK_PER_S)

// ****************************************
// lamp patterns
// ****************************************
`define LASC_SLOW_HALF_S 2
`define LASC_SLOW_HALF_TICKS (`LASC_SLOW_HALF_S * `LASC_TICK_PER_S)
`define LASC_FLT_GAP_S 5
`define LASC_FLT_GAP_TICKS (`LASC_FLT_GAP_S * `LASC_TICK_PER_S)
`define LASC_FLASH_ON_TICKS 5
`define LASC_FLASH_STEP_TICKS 10
`define LASC_FLASH_INTERNAL 2
`define LASC_FLASH_LINK 3
`define LASC_FLASH_SENSOR 4
`define LASC_FAST_PERIOD 2

// ****************************************
// widths and reset values
// ****************************************
`define LASC_TMR_W 12
`define LASC_PAT_W 8
`define LASC_PRE_W 32
`define LASC_LED_RST 1'b0

`endif

// ===== src/lasc_pkg.sv
// types shared by the leak alarm status controller
package lasc_pkg;

    // controller modes
    typedef enum logic [2:0] {
        MD_NORMAL,
        MD_ALARM,
        MD_DELAY,
        MD_TEST,
        MD_FAULT
    } lasc_mode_t;

    // fault class shown on the lamp
    typedef enum logic [1:0] {
        FLT_NONE,
        FLT_INTERNAL,
        FLT_LINK,
        FLT_SENSOR
    } lasc_fault_t;

    // sensed conditions
    typedef struct packed {
        logic leak;
        logic linkOk;
        logic sensorFail;
        logic boardFail;
    } lasc_sense_t;

endpackage

// ===== src/lasc_top.sv
// leak alarm mode controller driving the status lamp
`include "lasc_map.svh"

module lasc_top #(
    parameter int FAST_CYCLES = `LASC_FAST_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // sensed conditions
    input lasc_pkg::lasc_sense_t sense,
    // service button, high while pressed
    input wire logic button,
    // status outputs
    output logic ledOut,
    output lasc_pkg::lasc_mode_t modeOut,
    output lasc_pkg::lasc_fault_t faultOut
);

    // ****************************************
    // state
    // ****************************************
    logic [`LASC_PRE_W-1:0] preCnt_reg;
    logic fastTick_reg;
    logic btnPrev_reg;
    logic pressEdge;
    logic [`LASC_PAT_W-1:0] settleCnt_reg;
    logic startupDone_reg;
    lasc_pkg::lasc_fault_t fault_reg;
    lasc_pkg::lasc_fault_t fault_next;
    logic faultAny;
    logic pressArmed_reg;
    logic [`LASC_PAT_W-1:0] pressWin_reg;
    lasc_pkg::lasc_mode_t mode_reg;
    lasc_pkg::lasc_mode_t mode_next;
    logic [`LASC_TMR_W-1:0] timer_reg;
    logic [`LASC_PAT_W-1:0] patCnt_reg;
    logic [`LASC_PAT_W-1:0] patPeriod;
    logic ledOut_reg;
    logic ledOut_next;

    // ****************************************
    // decoding helpers
    // ****************************************
    function automatic logic [`LASC_PAT_W-1:0] flashCount(input lasc_pkg::lasc_fault_t f);
        unique case (f)
            lasc_pkg::FLT_INTERNAL: flashCount = `LASC_PAT_W'(`LASC_FLASH_INTERNAL);
            lasc_pkg::FLT_LINK: flashCount = `LASC_PAT_W'(`LASC_FLASH_LINK);
            lasc_pkg::FLT_SENSOR: flashCount = `LASC_PAT_W'(`LASC_FLASH_SENSOR);
            lasc_pkg::FLT_NONE: flashCount = '0;
        endcase
    endfunction

    function automatic logic [`LASC_PAT_W-1:0] flashSpan(input lasc_pkg::lasc_fault_t f);
        flashSpan = `LASC_PAT_W'(flashCount(f) * `LASC_PAT_W'(`LASC_FLASH_STEP_TICKS));
    endfunction

    // ****************************************
    // base tick
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            preCnt_reg <= '0;
            fastTick_reg <= 1'b0;
        end else if (preCnt_reg == `LASC_PRE_W'(FAST_CYCLES - 1)) begin
            preCnt_reg <= '0;
            fastTick_reg <= 1'b1;
        end else begin
            preCnt_reg <= preCnt_reg + 1'b1;
            fastTick_reg <= 1'b0;
        end
    end

    // ****************************************
    // button edge
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            btnPrev_reg <= 1'b0;
        end else begin
            btnPrev_reg <= button;
        end
    end
    assign pressEdge = button & ~btnPrev_reg;

    // ****************************************
    // startup settling
    // ****************************************
    // settle before faults
    always_ff @(posedge clk) begin
        if (rst) begin
            settleCnt_reg <= '0;
            startupDone_reg <= 1'b0;
        end else if (fastTick_reg && !startupDone_reg) begin
            if (settleCnt_reg == `LASC_PAT_W'(`LASC_SETTLE_TICKS - 1)) begin
                startupDone_reg <= 1'b1;
            end
            settleCnt_reg <= settleCnt_reg + 1'b1;
        end
    end

    // ****************************************
    // fault classification
    // ****************************************
    always_comb begin
        fault_next = lasc_pkg::FLT_NONE;
        if (startupDone_reg) begin
            if (sense.boardFail) begin
                fault_next = lasc_pkg::FLT_INTERNAL;
            end else if (!sense.linkOk) begin
                fault_next = lasc_pkg::FLT_LINK;
            end else if (sense.sensorFail) begin
                fault_next = lasc_pkg::FLT_SENSOR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fault_reg <= lasc_pkg::FLT_NONE;
        end else begin
            fault_reg <= fault_next;
        end
    end
    assign faultAny = fault_reg != lasc_pkg::FLT_NONE;

    // ****************************************
    // double press window
    // ****************************************
    // press window
    always_ff @(posedge clk) begin
        if (rst) begin
            pressArmed_reg <= 1'b0;
            pressWin_reg <= '0;
        end else if (mode_reg != lasc_pkg::MD_NORMAL || mode_next != lasc_pkg::MD_NORMAL) begin
            pressArmed_reg <= 1'b0;
            pressWin_reg <= '0;
        end else if (!pressArmed_reg) begin
            pressArmed_reg <= pressEdge;
            pressWin_reg <= '0;
        end else if (fastTick_reg) begin
            if (pressWin_reg == `LASC_PAT_W'(`LASC_PRESS_WIN_TICKS - 1)) begin
                pressArmed_reg <= 1'b0;
            end
            pressWin_reg <= pressWin_reg + 1'b1;
        end
    end

    // ****************************************
    // mode selection
    // ****************************************
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            lasc_pkg::MD_NORMAL: begin
                if (sense.leak) begin
                    mode_next = lasc_pkg::MD_ALARM;
                end else if (faultAny) begin
                    mode_next = lasc_pkg::MD_FAULT;
                end else if (pressEdge && pressArmed_reg) begin
                    mode_next = lasc_pkg::MD_TEST;
                end
            end
            lasc_pkg::MD_ALARM: begin
                if (!sense.leak) begin
                    mode_next = lasc_pkg::MD_DELAY;
                end
            end
            lasc_pkg::MD_DELAY: begin
                if (sense.leak) begin
                    mode_next = lasc_pkg::MD_ALARM;
                end else if (fastTick_reg
                        && timer_reg == `LASC_TMR_W'(`LASC_DELAY_TICKS - 1)) begin
                    mode_next = faultAny ? lasc_pkg::MD_FAULT : lasc_pkg::MD_NORMAL;
                end
            end
            lasc_pkg::MD_TEST: begin
                if (sense.leak) begin
                    mode_next = lasc_pkg::MD_ALARM;
                end else if (faultAny) begin
                    mode_next = lasc_pkg::MD_FAULT;
                end else if (pressEdge) begin
                    mode_next = lasc_pkg::MD_NORMAL;
                end else if (fastTick_reg
                        && timer_reg == `LASC_TMR_W'(`LASC_TEST_TICKS - 1)) begin
                    mode_next = lasc_pkg::MD_NORMAL;
                end
            end
            lasc_pkg::MD_FAULT: begin
                if (sense.leak) begin
                    mode_next = lasc_pkg::MD_ALARM;
                end else if (!faultAny) begin
                    mode_next = lasc_pkg::MD_DELAY;
                end
            end
            default: mode_next = lasc_pkg::MD_NORMAL;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= lasc_pkg::MD_NORMAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ****************************************
    // mode timer
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst || mode_next != mode_reg) begin
            timer_reg <= '0;
        end else if (fastTick_reg && timer_reg != '1) begin
            timer_reg <= timer_reg + 1'b1;
        end
    end

    // ****************************************
    // lamp pattern
    // ****************************************
    always_comb begin
        unique case (mode_reg)
            lasc_pkg::MD_NORMAL: patPeriod = `LASC_PAT_W'(2 * `LASC_SLOW_HALF_TICKS);
            lasc_pkg::MD_FAULT: patPeriod = `LASC_PAT_W'(flashSpan(fault_reg)
                - `LASC_PAT_W'(`LASC_FLASH_STEP_TICKS - `LASC_FLASH_ON_TICKS)
                + `LASC_PAT_W'(`LASC_FLT_GAP_TICKS));
            default: patPeriod = `LASC_PAT_W'(`LASC_FAST_PERIOD);
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || mode_next != mode_reg || fault_next != fault_reg) begin
            patCnt_reg <= '0;
        end else if (fastTick_reg) begin
            if (patCnt_reg >= patPeriod - 1'b1) begin
                patCnt_reg <= '0;
            end else begin
                patCnt_reg <= patCnt_reg + 1'b1;
            end
        end
    end

    always_comb begin
        ledOut_next = `LASC_LED_RST;
        unique case (mode_reg)
            lasc_pkg::MD_NORMAL: ledOut_next = patCnt_reg < `LASC_PAT_W'(`LASC_SLOW_HALF_TICKS);
            lasc_pkg::MD_ALARM: ledOut_next = patCnt_reg == '0;
            lasc_pkg::MD_TEST: ledOut_next = patCnt_reg == '0;
            lasc_pkg::MD_DELAY: ledOut_next = 1'b1;
            lasc_pkg::MD_FAULT: ledOut_next = patCnt_reg < flashSpan(fault_reg)
                && (patCnt_reg % `LASC_PAT_W'(`LASC_FLASH_STEP_TICKS))
                < `LASC_PAT_W'(`LASC_FLASH_ON_TICKS);
            default: ledOut_next = `LASC_LED_RST;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ledOut_reg <= `LASC_LED_RST;
        end else begin
            ledOut_reg <= ledOut_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign ledOut = ledOut_reg;
    assign modeOut = mode_reg;
    assign faultOut = fault_reg;

    // ****************************************
    // checks
    // ****************************************
    // leak forces alarm
    leak_alarm_a: assert property (@(posedge clk) disable iff (rst)
        sense.leak |=> mode_reg == lasc_pkg::MD_ALARM)
        else $error("leak did not enter alarm");
    delay_entry_a: assert property (@(posedge clk) disable iff (rst)
        mode_reg == lasc_pkg::MD_ALARM && !sense.leak |=> mode_reg == lasc_pkg::MD_DELAY)
        else $error("alarm clear did not enter delay");
    // without a leak, delay ends only at its full count
    delay_exit_a: assert property (@(posedge clk) disable iff (rst)
        mode_reg == lasc_pkg::MD_DELAY && !sense.leak && mode_next != lasc_pkg::MD_DELAY
        |-> fastTick_reg && timer_reg == `LASC_TMR_W'(`LASC_DELAY_TICKS - 1))
        else $error("delay left early");
    delay_lamp_a: assert property (@(posedge clk) disable iff (rst)
        mode_reg == lasc_pkg::MD_DELAY ##1 mode_reg == lasc_pkg::MD_DELAY |-> ledOut_reg)
        else $error("lamp dark in delay");
    test_entry_a: assert property (@(posedge clk) disable iff (rst)
        mode_reg == lasc_pkg::MD_NORMAL && !sense.leak && !faultAny
        && pressArmed_reg && pressEdge |=> mode_reg == lasc_pkg::MD_TEST)
        else $error("double press did not start test");
    test_limit_a: assert property (@(posedge clk) disable iff (rst)
        mode_reg == lasc_pkg::MD_TEST |-> timer_reg < `LASC_TMR_W'(`LASC_TEST_TICKS))
        else $error("test overran");
    test_abort_a: assert property (@(posedge clk) disable iff (rst)
        mode_reg == lasc_pkg::MD_TEST && pressEdge && !sense.leak && !faultAny
        |=> mode_reg == lasc_pkg::MD_NORMAL)
        else $error("press did not end test");
    sensor_gate_a: assert property (@(posedge clk) disable iff (rst)
        fault_reg == lasc_pkg::FLT_SENSOR |-> $past(sense.linkOk) && $past(sense.sensorFail))
        else $error("sensor fault without link");
    startup_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !startupDone_reg |-> mode_reg != lasc_pkg::MD_FAULT && !faultAny)
        else $error("fault shown before settling");
    fault_gap_a: assert property (@(posedge clk) disable iff (rst)
        mode_reg == lasc_pkg::MD_FAULT && patCnt_reg >= flashSpan(fault_reg)
        |=> !ledOut_reg)
        else $error("lamp lit in fault gap");

endmodule

// ===== verif/lasc_sensor_model.sv
// behavioural gas sensor and service button facing the controller
module lasc_sensor_model #(
    parameter int LAG = 3
) (
    // clock
    input wire logic clk,
    // sensor link outputs
    output logic leak,
    output logic linkOk,
    output logic sensorFail,
    // service button
    output logic button
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // requested sensor state
    // ****************************************
    logic gasSeen;
    logic plugged;
    logic selfErr;
    logic [2:0] pipe [LAG];

    initial begin
        gasSeen = 1'b0;
        plugged = 1'b1;
        selfErr = 1'b0;
        leak = 1'b0;
        linkOk = 1'b1;
        sensorFail = 1'b0;
        button = 1'b0;
        foreach (pipe[i]) pipe[i] = 3'h2;
    end

    // ****************************************
    // slow answer through a lag line
    // ****************************************
    always @(negedge clk) begin
        pipe[0] <= {gasSeen, plugged, selfErr};
        for (int i = 1; i < LAG; i++) pipe[i] <= pipe[i - 1];
    end

    always @(negedge clk) begin
        linkOk <= pipe[LAG - 1][1];
        // status bit is noise without a link
        sensorFail <= pipe[LAG - 1][1] ? pipe[LAG - 1][0] : ~sensorFail;
        leak <= pipe[LAG - 1][1] & pipe[LAG - 1][2];
    end

    task automatic press(input int holdClks);
        @(negedge clk);
        button = 1'b1;
        repeat (holdClks) @(negedge clk);
        button = 1'b0;
        @(negedge clk);
    endtask
endmodule

// ===== verif/leak_alarm_status_controller_tb_top.sv
// self-checking testbench of the leak alarm status controller
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin failCount++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module leak_alarm_status_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // signals
    // ****************************************
    localparam int FC = 4;
    localparam int DLY = 3000 * FC;
    logic clk;
    logic rst;
    logic boardFail;
    logic leak;
    logic linkOk;
    logic sensorFail;
    logic button;
    logic ledOut;
    lasc_pkg::lasc_sense_t sense;
    lasc_pkg::lasc_mode_t modeOut;
    lasc_pkg::lasc_fault_t faultOut;
    int failCount = 0;
    int nTests = 0;
    int seed = 65;
    int nRise;
    int maxHi;
    int maxLo;
    int gap;
    time t0;
    // fault table: board, plugged, sensor error, class, flashes
    int fltQ[$] = '{1, 0, 1, 1, 2, 0, 0, 1, 2, 3, 0, 1, 1, 3, 4};

    assign sense = '{leak: leak, linkOk: linkOk, sensorFail: sensorFail, boardFail: boardFail};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    lasc_top #(.FAST_CYCLES(FC)) i_dut (
        .clk(clk),
        .rst(rst),
        .sense(sense),
        .button(button),
        .ledOut(ledOut),
        .modeOut(modeOut),
        .faultOut(faultOut)
    );

    lasc_sensor_model #(.LAG(3)) i_partner (
        .clk(clk),
        .leak(leak),
        .linkOk(linkOk),
        .sensorFail(sensorFail),
        .button(button)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic summarize();
        if (failCount == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic waitMode(input lasc_pkg::lasc_mode_t m, input int lim);
        int c;
        c = 0;
        while (modeOut !== m && c < lim) begin
            @(negedge clk);
            c++;
        end
        `CHK(modeOut, m)
    endtask

    task automatic checkSpan(input int lo, input int hi);
        int el;
        el = int'(($time - t0) / 4);
        `CHK(el >= lo && el <= hi, 1'b1)
    endtask

    task automatic checkPat(input int n, input int rises, input int hiRun, input int loRun);
        int h;
        int l;
        logic prev;
        h = 0;
        l = 0;
        nRise = 0;
        maxHi = 0;
        maxLo = 0;
        repeat (8) @(negedge clk);
        prev = ledOut;
        repeat (n) begin
            @(negedge clk);
            h = (ledOut === 1'b1) ? h + 1 : 0;
            l = (ledOut === 1'b0) ? l + 1 : 0;
            nRise += (ledOut === 1'b1 && prev !== 1'b1) ? 1 : 0;
            maxHi = (h > maxHi) ? h : maxHi;
            maxLo = (l > maxLo) ? l : maxLo;
            prev = ledOut;
        end
        `CHK(nRise, rises)
        `CHK(maxHi, hiRun)
        `CHK(maxLo, loRun)
    endtask

    task automatic checkFlt(input int n);
        checkPat(2 * (n * 10 + 45) * FC, 2 * n, 5 * FC, 50 * FC);
    endtask

    initial begin
        #(4 * 70000);
        failCount++;
        summarize();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        boardFail = 1'b1;
        repeat (4) @(negedge clk);
        `CHK({ledOut, modeOut, faultOut}, {1'b0, lasc_pkg::MD_NORMAL, lasc_pkg::FLT_NONE})
        rst = 1'b0;
        repeat (20) @(negedge clk);
        `CHK({modeOut, faultOut}, {lasc_pkg::MD_NORMAL, lasc_pkg::FLT_NONE})
        waitMode(lasc_pkg::MD_FAULT, 80);
        for (int i = 0; i < fltQ.size(); i += 5) begin
            boardFail = fltQ[i][0];
            i_partner.plugged = fltQ[i + 1][0];
            i_partner.selfErr = fltQ[i + 2][0];
            repeat (12) @(negedge clk);
            `CHK(faultOut, lasc_pkg::lasc_fault_t'(fltQ[i + 3]))
            `CHK(modeOut, lasc_pkg::MD_FAULT)
            checkFlt(fltQ[i + 4]);
        end
        i_partner.gasSeen = 1'b1;
        waitMode(lasc_pkg::MD_ALARM, 10);
        checkPat(80, 10, FC, FC);
        i_partner.gasSeen = 1'b0;
        waitMode(lasc_pkg::MD_DELAY, 10);
        t0 = $time;
        checkPat(100, 0, 100, 0);
        waitMode(lasc_pkg::MD_FAULT, DLY + 40);
        checkSpan(DLY - FC - 2, DLY + 2);
        i_partner.selfErr = 1'b0;
        waitMode(lasc_pkg::MD_DELAY, 20);
        t0 = $time;
        waitMode(lasc_pkg::MD_NORMAL, DLY + 40);
        checkSpan(DLY - FC - 2, DLY + 2);
        checkPat(2 * 40 * FC, 2, 20 * FC, 20 * FC);
        i_partner.press(1 + {$random(seed)} % 6);
        repeat (60 * FC) @(negedge clk);
        i_partner.press(1 + {$random(seed)} % 6);
        `CHK(modeOut, lasc_pkg::MD_NORMAL)
        gap = 8 + {$random(seed)} % 150;
        repeat (gap) @(negedge clk);
        i_partner.press(1 + {$random(seed)} % 6);
        waitMode(lasc_pkg::MD_TEST, 4);
        checkPat(80, 10, FC, FC);
        i_partner.press(1);
        waitMode(lasc_pkg::MD_NORMAL, 4);
        repeat (8) @(negedge clk);
        i_partner.press(2);
        i_partner.press(2);
        waitMode(lasc_pkg::MD_TEST, 4);
        t0 = $time;
        waitMode(lasc_pkg::MD_NORMAL, DLY + 40);
        checkSpan(DLY - FC - 4, DLY + 2);
        // mid-run reset while a fault shows
        boardFail = 1'b1;
        waitMode(lasc_pkg::MD_FAULT, 80);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        `CHK({ledOut, modeOut, faultOut}, {1'b1, lasc_pkg::MD_NORMAL, lasc_pkg::FLT_NONE})
        waitMode(lasc_pkg::MD_FAULT, 80);
        summarize();
    end
endmodule
